// ### design/rlt_auto_reload_timer.sv
// Functional notes
// RULE1: select bit picks cpu or external clock
// RULE2: ratio field divides by two to power
// RULE3: run enable clear freezes prescaler and counter
// RULE4: force reload bit always reads zero
// RULE5: force reload loads counter, clears prescaler
// RULE6: overflow past ffh sets overflow flag
// RULE7: reading control status register clears flag
// RULE8: irq enable gates overflow interrupt request
// RULE9: counter register reads live, writes on fly
// RULE10: two capture results read-only, reset zero
// RULE11: overflow reloads counter and updates pwm outputs
// RULE12: each channel has its own output enable
// RULE13: polarity bit inverts channel output immediately
// RULE14: duty register sets second pwm edge
// RULE15: counter increments on each prescaler tick
`timescale 1ns/10ps
`default_nettype none
module rlt_auto_reload_timer
  import rlt_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic extClockIn,
  output logic [3:0] pwmOut,
  output logic [3:0] pwmOutEn,
  output logic irq
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  rlt_csr_s csr_r;
  rlt_pwmctl_s pwmCtl_r;
  logic [7:0] duty_r [4];
  logic [7:0] reloadData_r;
  logic [7:0] counter_r;
  logic [7:0] captureCtl_r;
  logic irqStatus_r;
  logic irqMask_r;

  // ----------------------------------------------------------------
  // write channel holding
  // ----------------------------------------------------------------
  rlt_wr_e wrState_r;
  logic awHeld_r;
  logic [7:0] awAddr_r;
  logic wHeld_r;
  logic [7:0] wData_r;
  logic wLane_r;
  logic wrFire;
  logic [7:0] wrIdx;
  logic wrMapped;
  logic wrCsr;
  logic wrCar;

  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready = !wHeld_r;
  assign wrFire = awHeld_r && wHeld_r && (wrState_r == WR_IDLE);
  assign wrIdx = regIndex(awAddr_r);
  // byte lane 0 carries every register, other lanes are ignored
  assign wrCsr = wrFire && wLane_r && (wrIdx == IDX_CSR);
  assign wrCar = wrFire && wLane_r && (wrIdx == IDX_CAR);
  assign wrMapped = (wrIdx >= IDX_DUTY3) && (wrIdx <= IDX_IRQ_MASK);

  // one address and one data word are held, so they may arrive in either order
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
    end else if (s_axi_awvalid && !awHeld_r) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wHeld_r <= 1'b0;
      wData_r <= 8'h00;
      wLane_r <= 1'b0;
    end else if (s_axi_wvalid && !wHeld_r) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata[7:0];
      wLane_r <= s_axi_wstrb[0];
    end else if (wrFire) begin
      wHeld_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // write response
  // ----------------------------------------------------------------
  // the response waits for bready; a second pair may be held meanwhile
  // but is applied only once the response has gone
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrState_r <= WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      unique case (wrState_r)
        WR_IDLE: begin
          if (wrFire) begin
            wrState_r <= WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wrState_r <= WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wrState_r <= WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // capture control is plain storage, the capture itself is not built
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pwmCtl_r <= RST_REG8;
      reloadData_r <= RST_REG8;
      captureCtl_r <= RST_REG8;
      irqMask_r <= IRQ_MASK_RST;
      for (int i = 0; i < 4; i++) begin
        duty_r[i] <= RST_REG8;
      end
    end else if (wrFire && wLane_r) begin
      if (wrIdx == IDX_PWMCTL) begin
        pwmCtl_r <= wData_r;
      end
      if (wrIdx == IDX_RELOAD) begin
        reloadData_r <= wData_r;
      end
      if (wrIdx == IDX_CAPCSR) begin
        captureCtl_r <= wData_r;
      end
      if (wrIdx == IDX_IRQ_MASK) begin
        irqMask_r <= wData_r[0];
      end
      for (int i = 0; i < 4; i++) begin
        if (wrIdx == IDX_DUTY0 - 8'(i)) begin
          duty_r[i] <= wData_r;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // external clock input and prescaler
  // ----------------------------------------------------------------
  logic extSync1_r;
  logic extSync2_r;
  logic extPrev_r;
  logic inTick;
  logic forceStrobe;
  logic prescaleTick;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      extSync1_r <= 1'b0;
      extSync2_r <= 1'b0;
      extPrev_r <= 1'b0;
    end else begin
      extSync1_r <= extClockIn;
      extSync2_r <= extSync1_r;
      extPrev_r <= extSync2_r;
    end
  end

  // the external clock must stay below a quarter of the cpu clock
  assign inTick = csr_r.extClockSelect ? (extSync2_r && !extPrev_r) : 1'b1; // RULE1
  assign forceStrobe = wrCsr && wData_r[CSR_FORCE_BIT]; // RULE5

  rlt_prescaler u_prescaler (
    .clock(clock),
    .rst_b(rst_b),
    .inTick(inTick),
    .enable(csr_r.counterRunEnable),
    .clear(forceStrobe),
    .prescaleRatio(csr_r.prescaleRatio),
    .tick(prescaleTick)
  );

  // ----------------------------------------------------------------
  // counter, reload and overflow
  // ----------------------------------------------------------------
  logic overflowEvent;
  logic reloadEvent;
  logic csrRead;

  // a software load in the same cycle wins, so that overflow is dropped
  assign overflowEvent = prescaleTick && (counter_r == 8'hff) && !wrCar && !forceStrobe; // RULE6
  assign reloadEvent = overflowEvent || forceStrobe;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      counter_r <= RST_REG8;
    end else if (wrCar) begin
      counter_r <= wData_r; // RULE9
    end else if (forceStrobe) begin
      counter_r <= reloadData_r; // RULE5
    end else if (overflowEvent) begin
      counter_r <= reloadData_r; // RULE11
    end else if (prescaleTick) begin
      counter_r <= counter_r + 8'h01; // RULE15 RULE3
    end
  end

  // ----------------------------------------------------------------
  // control and status register
  // ----------------------------------------------------------------
  // the force bit is never loaded, its strobe is taken from the write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      csr_r <= RST_REG8; // RULE4
    end else begin
      if (wrCsr) begin
        csr_r.extClockSelect <= wData_r[7];
        csr_r.prescaleRatio <= wData_r[6:4];
        csr_r.counterRunEnable <= wData_r[CSR_RUN_BIT];
        csr_r.overflowIrqEnable <= wData_r[1];
      end
      // a set in the cycle of the clearing read wins, so no overflow is lost
      if (overflowEvent) begin
        csr_r.overflowFlag <= 1'b1; // RULE6
      end else if (csrRead) begin
        csr_r.overflowFlag <= 1'b0; // RULE7
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // status is sticky until software writes a one, the mask only gates the pin
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irqStatus_r <= 1'b0;
    end else if (overflowEvent && csr_r.overflowIrqEnable) begin
      irqStatus_r <= 1'b1; // RULE8
    end else if (wrFire && wLane_r && (wrIdx == IDX_IRQ_STATUS) && wData_r[0]) begin
      irqStatus_r <= 1'b0;
    end
  end

  assign irq = irqStatus_r && irqMask_r; // RULE8

  // ----------------------------------------------------------------
  // pwm channels
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < 4; ch++) begin : g_pwm
    rlt_pwm_channel u_channel (
      .clock(clock),
      .rst_b(rst_b),
      .counterValue(counter_r),
      .dutyValue(duty_r[ch]),
      .reloadEvent(reloadEvent), // RULE11
      .outEnable(pwmCtl_r.outEnable[ch]),
      .channelPolarity(pwmCtl_r.channelPolarity[ch]),
      .pwmOut(pwmOut[ch]),
      .pwmOutEn(pwmOutEn[ch])
    );
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic [7:0] rdIdx;
  logic [7:0] rdValue;
  logic rdMapped;

  assign s_axi_arready = !s_axi_rvalid;
  assign rdIdx = regIndex(s_axi_araddr);
  assign csrRead = s_axi_arvalid && s_axi_arready && (rdIdx == IDX_CSR); // RULE7

  always_comb begin
    rdValue = 8'h00;
    rdMapped = 1'b1;
    unique case (rdIdx)
      IDX_DUTY3: rdValue = duty_r[3];
      IDX_DUTY2: rdValue = duty_r[2];
      IDX_DUTY1: rdValue = duty_r[1];
      IDX_DUTY0: rdValue = duty_r[0];
      IDX_PWMCTL: rdValue = pwmCtl_r;
      IDX_CSR: rdValue = csr_r; // RULE4
      IDX_CAR: rdValue = counter_r; // RULE9
      IDX_RELOAD: rdValue = reloadData_r;
      IDX_CAPCSR: rdValue = captureCtl_r;
      IDX_CAPRES1: rdValue = RST_REG8; // RULE10
      IDX_CAPRES2: rdValue = RST_REG8; // RULE10
      IDX_IRQ_STATUS: rdValue = {7'h00, irqStatus_r};
      IDX_IRQ_MASK: rdValue = {7'h00, irqMask_r};
      default: rdMapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // read data register
  // ----------------------------------------------------------------
  // data is registered, so the answer always comes one cycle after the address
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rdValue};
      s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : rlt_auto_reload_timer
`default_nettype wire

// ### design/rlt_pkg.sv
`default_nettype none
package rlt_pkg;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_DUTY3 = 8'h31;
  localparam logic [7:0] IDX_DUTY2 = 8'h32;
  localparam logic [7:0] IDX_DUTY1 = 8'h33;
  localparam logic [7:0] IDX_DUTY0 = 8'h34;
  localparam logic [7:0] IDX_PWMCTL = 8'h35;
  localparam logic [7:0] IDX_CSR = 8'h36;
  localparam logic [7:0] IDX_CAR = 8'h37;
  localparam logic [7:0] IDX_RELOAD = 8'h38;
  localparam logic [7:0] IDX_CAPCSR = 8'h39;
  localparam logic [7:0] IDX_CAPRES1 = 8'h3a;
  localparam logic [7:0] IDX_CAPRES2 = 8'h3b;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h3c;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h3d;

  // ----------------------------------------------------------------
  // control and status field positions
  // ----------------------------------------------------------------
  localparam int CSR_RUN_BIT = 3;
  localparam int CSR_FORCE_BIT = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic IRQ_MASK_RST = 1'b1;

  // ----------------------------------------------------------------
  // bus answers and types
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic extClockSelect;
    logic [2:0] prescaleRatio;
    logic counterRunEnable;
    logic forceReload;
    logic overflowIrqEnable;
    logic overflowFlag;
  } rlt_csr_s;

  typedef struct packed {
    logic [3:0] outEnable;
    logic [3:0] channelPolarity;
  } rlt_pwmctl_s;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } rlt_wr_e;

  function automatic logic [7:0] regIndex(input logic [7:0] addr);
    regIndex = {2'h0, addr[7:2]};
  endfunction : regIndex

endpackage : rlt_pkg
`default_nettype wire

// ### design/rlt_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module rlt_prescaler
  import rlt_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic inTick,
  input wire logic enable,
  input wire logic clear,
  input wire logic [2:0] prescaleRatio,
  output logic tick
);

  // ----------------------------------------------------------------
  // 7-bit divide by two to the ratio
  // ----------------------------------------------------------------
  logic [6:0] count_r;
  logic [6:0] mask;

  assign mask = 7'(({7'h00, 1'b1} << prescaleRatio) - 8'h01);
  // ratio 0 leaves the mask empty so every input tick passes
  assign tick = enable && inTick && !clear && ((count_r & mask) == mask); // RULE2

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= 7'h00;
    end else if (clear) begin
      count_r <= 7'h00; // RULE5
    end else if (enable && inTick) begin
      count_r <= count_r + 7'h01;
    end
  end

endmodule : rlt_prescaler
`default_nettype wire

// ### design/rlt_pwm_channel.sv
`timescale 1ns/10ps
`default_nettype none
module rlt_pwm_channel
  import rlt_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] counterValue,
  input wire logic [7:0] dutyValue,
  input wire logic reloadEvent,
  input wire logic outEnable,
  input wire logic channelPolarity,
  output logic pwmOut,
  output logic pwmOutEn
);

  // ----------------------------------------------------------------
  // compare value follows the duty register at each reload
  // ----------------------------------------------------------------
  logic [7:0] channelCompareValue_r;
  logic level;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      channelCompareValue_r <= RST_REG8;
    end else if (reloadEvent) begin
      channelCompareValue_r <= dutyValue; // RULE14
    end
  end

  // high up to the compare point when polarity is clear
  assign level = (counterValue <= channelCompareValue_r) ^ channelPolarity; // RULE13

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pwmOut <= 1'b0;
      pwmOutEn <= 1'b0;
    end else begin
      pwmOut <= outEnable ? level : 1'b0; // RULE12
      pwmOutEn <= outEnable; // RULE12
    end
  end

endmodule : rlt_pwm_channel
`default_nettype wire

// ### tb/rlt_auto_reload_timer_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rlt_auto_reload_timer_monitor
  import rlt_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] pwmOut,
  input wire logic [3:0] pwmOutEn
);
  // ----------------------------------------------------------------
  // read index seen at the address handshake, so data can be judged
  // ----------------------------------------------------------------
  logic [5:0] rdIdx_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) rdIdx_r <= 6'h00;
    else if (s_axi_arvalid && s_axi_arready) rdIdx_r <= s_axi_araddr[7:2];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_pwm_off; (pwmOut & ~pwmOutEn) == 4'h0; endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm level on disabled channel");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_en_by_write; $changed(pwmOutEn) |-> $past(s_axi_bvalid); endproperty
  a_en_by_write: assert property (p_en_by_write) else $error("enable moved unwritten");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_rresp;
    $rose(s_axi_rvalid) |-> s_axi_rresp ==
      ((rdIdx_r < 6'h31 || rdIdx_r > 6'h3d) ? RESP_SLVERR : RESP_OKAY);
  endproperty
  a_rresp: assert property (p_rresp) else $error("read response code wrong");
  property p_force_zero; s_axi_rvalid && rdIdx_r == IDX_CSR[5:0] |-> !s_axi_rdata[CSR_FORCE_BIT];
  endproperty
  a_force_zero: assert property (p_force_zero) else $error("force bit read as one");
  property p_cap_zero;
    s_axi_rvalid && (rdIdx_r == IDX_CAPRES1[5:0] || rdIdx_r == IDX_CAPRES2[5:0])
      |-> s_axi_rdata == 32'h0;
  endproperty
  a_cap_zero: assert property (p_cap_zero) else $error("capture result not zero");
endmodule : rlt_auto_reload_timer_monitor
bind rlt_auto_reload_timer rlt_auto_reload_timer_monitor u_mon (.clock, .rst_b,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .pwmOut, .pwmOutEn);
`default_nettype wire

// ### tb/tb_auto_reload_pwm_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_auto_reload_pwm_timer import rlt_pkg::*;;
  // ----------------------------------------------------------------
  // bench signals and instance
  // ----------------------------------------------------------------
  logic clock = 1'b0, rst_b = 1'b0, extClockIn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] pwmOut, pwmOutEn;
  int n_fail = 0;
  int checks = 0;
  always #50 clock = ~clock;
  rlt_auto_reload_timer uut (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .extClockIn, .pwmOut, .pwmOutEn, .irq);
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic bound(input int n);
    if (n > 100) begin
      n_fail++;
      $display("BAD handshake expected answer seen timeout");
      tally_and_finish();
    end
  endtask : bound
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chkIn(input string nm, input logic [7:0] lo, hi, input logic [31:0] g);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_fail++;
      $display("BAD %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask : chkIn
  // ready is sampled mid-cycle, where it already shows what the next edge will see
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    int n;
    logic a, w, ta, tw;
    @(posedge clock);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    a = 1'b1;
    w = 1'b1;
    n = 0;
    while (a || w) begin
      @(negedge clock);
      ta = a && s_axi_awready;
      tw = w && s_axi_wready;
      @(posedge clock);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        a = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        w = 1'b0;
      end
      n++;
      bound(n);
    end
    @(negedge clock);
    while (s_axi_bvalid !== 1'b1) begin
      @(negedge clock);
      n++;
      bound(n);
    end
    rs = s_axi_bresp;
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdReg(input logic [5:0] i);
    int n;
    @(posedge clock);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    @(negedge clock);
    while (s_axi_arready !== 1'b1) begin
      @(negedge clock);
      n++;
      bound(n);
    end
    @(posedge clock);
    s_axi_arvalid <= 1'b0;
    @(negedge clock);
    while (s_axi_rvalid !== 1'b1) begin
      @(negedge clock);
      n++;
      bound(n);
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask : rdReg
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic tReset;
    for (int i = 'h31; i <= 'h3d; i++) begin
      rdReg(i[5:0]);
      chk("reset value", {31'h0, 1'(i == 'h3d)}, rd);
    end
    chk("reset enables", 32'h0, 32'(pwmOutEn));
    chk("reset irq", 32'h0, 32'(irq));
  endtask : tReset
  task automatic tRegs;
    wr(6'h34, 8'hff);
    rdReg(6'h34);
    chk("duty0", 32'hff, rd);
    wr(6'h3a, 8'h55);
    rdReg(6'h3a);
    chk("capture", 32'h0, rd);
    wr(6'h36, 8'h04);
    rdReg(6'h36);
    chk("force read", 32'h0, rd);
    rdReg(6'h10);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(rs));
    wr(6'h10, 8'h00);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(rs));
  endtask : tRegs
  task automatic tCount;
    logic [31:0] c;
    for (int r = 0; r <= 3; r += 3) begin
      wr(6'h37, 8'h10);
      wr(6'h36, {1'b0, 3'(r), 4'h8});
      repeat (64) @(posedge clock);
      wr(6'h36, 8'h00);
      rdReg(6'h37);
      chkIn("count", 8'h0f + 8'(64 >> r), 8'h11 + 8'(76 >> r), rd);
      c = rd;
      repeat (20) @(posedge clock);
      rdReg(6'h37);
      chk("frozen", c, rd);
    end
    wr(6'h36, 8'h08);
    wr(6'h37, 8'h80);
    rdReg(6'h37);
    chkIn("live load", 8'h80, 8'h88, rd);
    wr(6'h36, 8'h00);
  endtask : tCount
  task automatic tOverflow;
    wr(6'h38, 8'hf0);
    wr(6'h37, 8'hfd);
    wr(6'h36, 8'h0a);
    repeat (8) @(posedge clock);
    wr(6'h36, 8'h02);
    rdReg(6'h37);
    chkIn("reloaded", 8'hf0, 8'hfc, rd);
    wr(6'h37, 8'h22);
    wr(6'h36, 8'h06);
    rdReg(6'h37);
    chk("force reload", 32'hf0, rd);
    rdReg(6'h36);
    chk("flag set", 32'h03, rd);
    rdReg(6'h36);
    chk("flag cleared", 32'h02, rd);
    chk("irq raised", 32'h1, 32'(irq));
    wr(6'h3c, 8'h01);
    repeat (2) @(posedge clock);
    chk("irq cleared", 32'h0, 32'(irq));
    wr(6'h3d, 8'h00);
    wr(6'h37, 8'hfe);
    wr(6'h36, 8'h0a);
    repeat (10) @(posedge clock);
    wr(6'h36, 8'h02);
    chk("irq masked", 32'h0, 32'(irq));
    wr(6'h3d, 8'h01);
    repeat (2) @(posedge clock);
    chk("irq unmasked", 32'h1, 32'(irq));
    rdReg(6'h36);
    chk("flag again", 32'h03, rd);
    wr(6'h3c, 8'h01);
    wr(6'h37, 8'hfe);
    wr(6'h36, 8'h08);
    repeat (10) @(posedge clock);
    wr(6'h36, 8'h00);
    rdReg(6'h3c);
    chk("status off", 32'h0, rd);
    chk("irq off", 32'h0, 32'(irq));
    rdReg(6'h36);
    chk("flag no irq", 32'h01, rd);
  endtask : tOverflow
  task automatic tPwm;
    wr(6'h38, 8'h00);
    wr(6'h34, 8'h80);
    for (int i = 'h31; i <= 'h33; i++) wr(i[5:0], 8'h00);
    wr(6'h36, 8'h04);
    wr(6'h37, 8'h40);
    wr(6'h35, 8'h10);
    repeat (3) @(posedge clock);
    chk("pwm enable", 32'h11, {24'h0, pwmOutEn, pwmOut});
    wr(6'h35, 8'h11);
    repeat (3) @(posedge clock);
    chk("polarity", 32'h10, {24'h0, pwmOutEn, pwmOut});
    wr(6'h37, 8'h90);
    repeat (3) @(posedge clock);
    chk("second edge", 32'h11, {24'h0, pwmOutEn, pwmOut});
    wr(6'h35, 8'hf0);
    repeat (3) @(posedge clock);
    chk("all enabled", 32'hf0, {24'h0, pwmOutEn, pwmOut});
  endtask : tPwm
  task automatic tExt;
    wr(6'h37, 8'h00);
    wr(6'h36, 8'h88);
    for (int k = 0; k < 5; k++) begin
      repeat (4) @(posedge clock);
      extClockIn <= 1'b1;
      repeat (4) @(posedge clock);
      extClockIn <= 1'b0;
    end
    repeat (8) @(posedge clock);
    wr(6'h36, 8'h00);
    rdReg(6'h37);
    chk("ext count", 32'h05, rd);
  endtask : tExt
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    tReset();
    tRegs();
    tCount();
    tOverflow();
    tPwm();
    tExt();
    tally_and_finish();
  end
endmodule : tb_auto_reload_pwm_timer
`default_nettype wire
